// ===== abort_pkg.sv
// Shared constants for the core bus abort handling block.
// Assumes a single 50 MHz clock domain and synchronous active-low reset.
package abort_pkg;

    // Clock figures
    localparam int CLK_PERIOD_NS = 20;

    // Data geometry: one internal bus data phase is 64 bits
    localparam int PHASE_BYTES   = 8;
    localparam int PHASE_BITS    = 64;

    // Burst limits per memory width
    localparam logic [2:0] MAX_PHASES_64 = 3'h2;
    localparam logic [2:0] MAX_PHASES_32 = 3'h4;

    // Pad value for undelivered bytes
    localparam logic [7:0] PAD_BYTE      = 8'hFF;

    // Status bit position of the master-abort flag
    localparam int STAT_MABORT_BIT = 0;
    localparam logic [7:0] STAT_RESET    = 8'h00;

    // Transfer kinds
    localparam logic [1:0] KIND_READ     = 2'h0;
    localparam logic [1:0] KIND_WRITE    = 2'h1;
    localparam logic [1:0] KIND_FETCH    = 2'h2;
    localparam logic [1:0] KIND_PREFETCH = 2'h3;

    // Transfer sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } seq_state_type;

endpackage

// ===== data_pad.sv
// Data lane padding: replaces each byte lane not yet delivered with the pad value.
// Assumes the lane mask and data arrive on the same clock as the caller.
`timescale 1ns/10ps
module data_pad
    import abort_pkg::*;
#(
    parameter int LANES = PHASE_BYTES
) (
    // Incoming data and lane mask
    input  wire logic [LANES*8-1:0] data_i,
    input  wire logic [LANES-1:0]   keep_i,
    // Padded data
    output logic      [LANES*8-1:0] data_o
);

    // Each lane is kept or forced to the pad byte
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign data_o[g*8 +: 8] = keep_i[g] ? data_i[g*8 +: 8] : PAD_BYTE;
    end

endmodule

// ===== core_bus_abort_handling.sv
// Abort and error handling of the core bus interface unit toward the internal bus.
// Assumes the internal bus side reports per data phase: data valid, last phase, and abort kind.
// Functional notes
// - Log master-aborts (unclaimed) of own internal bus transactions
// - Unclaimed transaction sets flag, raises NMI
// - Relayed PCI master-abort is not logged
// - Master-aborted read returns FFH every byte
// - Aborted write entry removed, never retried
// - Target-abort read: valid data, then FFH
// - Target-aborts treated alike, not logged
// - Write bursts: two phases 64-bit, four 32-bit
// - Early-phase write target-abort discards remaining data
// - Final-phase write abort looks completed
// - Aborted prefetch leaves buffer invalid
// - Later fetch to those addresses refetches
`timescale 1ns/10ps
module core_bus_abort_handling
    import abort_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // Request from the core side
    input  wire logic                  req_valid_i,
    input  wire logic [1:0]            req_kind_i,
    input  wire logic [ADDR_W-1:0]     req_addr_i,
    input  wire logic [2:0]            req_phases_i,
    input  wire logic                  mem32_i,
    input  wire logic                  prefetch_en_i,
    // Internal bus completion events
    input  wire logic                  bus_data_valid_i,
    input  wire logic [PHASE_BITS-1:0] bus_data_i,
    input  wire logic                  bus_last_i,
    input  wire logic                  bus_no_claim_i,
    input  wire logic                  bus_relay_mabort_i,
    input  wire logic                  bus_target_abort_i,
    // Status clear from software side
    input  wire logic                  mabort_clear_i,
    // Request handshake and bus start
    output logic                       req_ready_o,
    output logic                       bus_start_o,
    output logic [ADDR_W-1:0]          bus_addr_o,
    output logic [2:0]                 bus_phases_o,
    // Read data toward the core
    output logic                       rd_valid_o,
    output logic [PHASE_BITS-1:0]      rd_data_o,
    output logic                       rd_last_o,
    // Write buffer entry release
    output logic                       wr_release_o,
    output logic                       wr_discard_o,
    // Prefetch buffer state
    output logic                       pf_valid_o,
    output logic [ADDR_W-1:0]          pf_addr_o,
    output logic                       pf_hit_o,
    // Status and interrupt
    output logic [7:0]                 status_o,
    output logic                       nmi_o
);

    // All state of the block
    typedef struct packed {
        seq_state_type     st;          // Sequencer state
        logic [1:0]        kind;        // Kind of transfer in flight
        logic [ADDR_W-1:0] addr;        // Address in flight
        logic [2:0]        phases;      // Data phases requested
        logic [2:0]        count;       // Data phases completed
        logic              aborted;     // Padding mode after an abort
        logic              ready;       // Request acceptance
        logic              start;       // Bus start pulse
        logic              rd_valid;    // Read data strobe
        logic [PHASE_BITS-1:0] rd_data; // Read data
        logic              rd_last;     // Last read phase
        logic              wr_release;  // Write entry removed
        logic              wr_discard;  // Untransferred write data dropped
        logic              pf_valid;    // Prefetch buffer valid
        logic [ADDR_W-1:0] pf_addr;     // Prefetch buffer address
        logic              pf_hit;      // Fetch served from prefetch buffer
        logic [7:0]        status;      // Interrupt status bits
        logic              nmi;         // NMI level to core
    } state_type;

    state_type cur;                     // Registered state
    state_type next_cur;                // Next state

    logic [PHASE_BITS-1:0] padded;      // Bus data with all lanes padded
    logic [2:0]            cap;         // Burst limit for current memory width
    logic                  fin;         // Transfer ends this cycle

    // The abort phase never carries live bytes, so every lane takes the pad value
    // Full pad: keep no lanes, used for lanes after an abort
    data_pad #(
        .LANES (PHASE_BYTES)
    ) u_pad (
        .data_i (bus_data_i),
        .keep_i ({PHASE_BYTES{1'b0}}),
        .data_o (padded)
    );

    // Next-state logic
    always_comb begin
        next_cur            = cur;
        next_cur.start      = 1'b0;
        next_cur.rd_valid   = 1'b0;
        next_cur.rd_last    = 1'b0;
        next_cur.wr_release = 1'b0;
        next_cur.wr_discard = 1'b0;
        next_cur.pf_hit     = 1'b0;
        // Burst cap follows the memory width present when the request is taken
        cap = mem32_i ? MAX_PHASES_32 : MAX_PHASES_64;
        fin = 1'b0;
        // Idle takes a request, busy follows the bus, done re-arms the handshake
        unique case (cur.st)
            ST_IDLE: begin
                // Ready rises one cycle after reset or after done
                next_cur.ready = 1'b1;
                if (req_valid_i && cur.ready) begin
                    next_cur.ready   = 1'b0;
                    next_cur.kind    = req_kind_i;
                    next_cur.addr    = req_addr_i;
                    next_cur.count   = 3'h0;
                    next_cur.aborted = 1'b0;
                    // Writes never burst past the memory width limit
                    if (req_kind_i == KIND_WRITE && req_phases_i > cap) begin
                        next_cur.phases = cap;
                    end else if (req_phases_i == 3'h0) begin
                        next_cur.phases = 3'h1;
                    end else begin
                        next_cur.phases = req_phases_i;
                    end
                    // A valid matching prefetch serves the fetch without a bus cycle
                    if (req_kind_i == KIND_FETCH && prefetch_en_i && cur.pf_valid
                        && cur.pf_addr == req_addr_i) begin
                        next_cur.pf_hit = 1'b1;
                        next_cur.st     = ST_DONE;
                    end else begin
                        // Invalid buffer forces a fresh fetch cycle
                        next_cur.start = 1'b1;
                        next_cur.st    = ST_BUSY;
                    end
                end
            end
            // No bus timeout: a target that never answers leaves the sequencer busy
            ST_BUSY: begin
                if (bus_no_claim_i || bus_relay_mabort_i) begin
                    // Master-abort: pad all remaining bytes
                    fin = 1'b1;
                    next_cur.aborted = 1'b1;
                    if (cur.kind != KIND_WRITE) begin
                        next_cur.rd_valid = 1'b1;
                        next_cur.rd_data  = padded;
                        next_cur.rd_last  = 1'b1;
                    end
                end else if (bus_target_abort_i) begin
                    // Both target sources handled alike, nothing logged
                    fin = 1'b1;
                    next_cur.aborted = 1'b1;
                    if (cur.kind != KIND_WRITE) begin
                        // Data already passed; the rest is padding
                        next_cur.rd_valid = 1'b1;
                        next_cur.rd_data  = padded;
                        next_cur.rd_last  = 1'b1;
                    end
                end else if (bus_data_valid_i) begin
                    // Normal data phase: count it and pass it on unchanged
                    next_cur.count = cur.count + 3'h1;
                    fin = bus_last_i || (cur.count + 3'h1 >= cur.phases);
                    if (cur.kind != KIND_WRITE) begin
                        next_cur.rd_valid = 1'b1;
                        next_cur.rd_data  = bus_data_i;
                        next_cur.rd_last  = fin;
                    end
                end
                // Bookkeeping common to every way a transfer ends
                if (fin) begin
                    next_cur.st = ST_DONE;
                    if (cur.kind == KIND_WRITE) begin
                        // Aborted entry removed, never retried
                        next_cur.wr_release = 1'b1;
                        // Early target-abort drops unsent phases
                        next_cur.wr_discard = bus_target_abort_i && !bus_data_valid_i
                                              && (cur.count + 3'h1 < cur.phases);
                        // Abort on final phase counts as a completed write
                    end
                    if (cur.kind == KIND_PREFETCH) begin
                        // Aborted prefetch leaves buffer unloaded and invalid
                        if (bus_target_abort_i || bus_no_claim_i || bus_relay_mabort_i) begin
                            next_cur.pf_valid = 1'b0;
                        end else begin
                            next_cur.pf_valid = 1'b1;
                            next_cur.pf_addr  = cur.addr;
                        end
                    end
                end
            end
            ST_DONE: begin
                // One spare cycle keeps the pulses of two transfers apart
                next_cur.st    = ST_IDLE;
                next_cur.ready = 1'b1;
            end
            default: begin
                // Illegal one-hot code: return to idle rather than hang
                next_cur.st = ST_IDLE;
            end
        endcase
        // Own unclaimed transfer logged; relayed abort is not
        if (mabort_clear_i) begin
            next_cur.status[STAT_MABORT_BIT] = 1'b0;
        end
        // Set wins over clear in the same cycle
        if (cur.st == ST_BUSY && bus_no_claim_i) begin
            next_cur.status[STAT_MABORT_BIT] = 1'b1;
        end
        // NMI level follows the logged flag
        next_cur.nmi = next_cur.status[STAT_MABORT_BIT];
    end

    // State register
    // Status must start clear so that no NMI follows reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cur        <= '0;
            cur.st     <= ST_IDLE;
            cur.status <= STAT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register
    assign req_ready_o  = cur.ready;
    assign bus_start_o  = cur.start;
    assign bus_addr_o   = cur.addr;
    assign bus_phases_o = cur.phases;
    assign rd_valid_o   = cur.rd_valid;
    assign rd_data_o    = cur.rd_data;
    assign rd_last_o    = cur.rd_last;
    assign wr_release_o = cur.wr_release;
    assign wr_discard_o = cur.wr_discard;
    assign pf_valid_o   = cur.pf_valid;
    assign pf_addr_o    = cur.pf_addr;
    assign pf_hit_o     = cur.pf_hit;
    assign status_o     = cur.status;
    assign nmi_o        = cur.nmi;

    // Checks on what the block drives
    // Logging and padding after aborts
    a_mabort_logged: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && bus_no_claim_i) |=> status_o[STAT_MABORT_BIT] && nmi_o)
        else $error("unclaimed transfer not logged");
    a_relay_unlogged: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && bus_relay_mabort_i && !bus_no_claim_i && !status_o[STAT_MABORT_BIT])
        |=> !status_o[STAT_MABORT_BIT])
        else $error("relayed master-abort was logged");
    a_mabort_pad: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && cur.kind != KIND_WRITE && bus_no_claim_i)
        |=> rd_valid_o && rd_last_o && rd_data_o == {PHASE_BYTES{PAD_BYTE}})
        else $error("master-aborted read not padded");
    a_relay_pad: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && cur.kind != KIND_WRITE && bus_relay_mabort_i)
        |=> rd_valid_o && rd_last_o && rd_data_o == {PHASE_BYTES{PAD_BYTE}})
        else $error("relayed master-abort read not padded");
    // Write buffer handling, then target-abort read padding and quiet status
    a_write_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && cur.kind == KIND_WRITE && bus_target_abort_i)
        |=> wr_release_o ##1 !bus_start_o)
        else $error("aborted write not released");
    a_mabort_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && cur.kind == KIND_WRITE && (bus_no_claim_i || bus_relay_mabort_i))
        |=> wr_release_o && !rd_valid_o)
        else $error("master-aborted write not released");
    a_discard_early: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && cur.kind == KIND_WRITE && bus_target_abort_i && !bus_no_claim_i
         && !bus_relay_mabort_i && !bus_data_valid_i && cur.count + 3'h1 < cur.phases)
        |=> wr_release_o && wr_discard_o)
        else $error("early write abort kept data");
    a_final_complete: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && cur.kind == KIND_WRITE && bus_target_abort_i && !bus_no_claim_i
         && !bus_relay_mabort_i && cur.count + 3'h1 >= cur.phases)
        |=> wr_release_o && !wr_discard_o)
        else $error("final-phase write abort not completed");
    a_tabort_pad: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && cur.kind == KIND_READ && bus_target_abort_i && !bus_no_claim_i
         && !bus_relay_mabort_i) |=> rd_data_o == {PHASE_BYTES{PAD_BYTE}})
        else $error("target-aborted read not padded");
    a_tabort_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && bus_target_abort_i && !bus_no_claim_i && !mabort_clear_i)
        |=> $stable(status_o))
        else $error("target-abort changed status");
    // Burst length and prefetch buffer
    a_burst_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (bus_start_o && cur.kind == KIND_WRITE)
        |-> bus_phases_o <= ($past(mem32_i) ? MAX_PHASES_32 : MAX_PHASES_64))
        else $error("write burst too long");
    a_prefetch_inval: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_BUSY && cur.kind == KIND_PREFETCH && bus_target_abort_i) |=> !pf_valid_o)
        else $error("aborted prefetch left valid");
    a_refetch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cur.st == ST_IDLE && cur.ready && req_valid_i && req_kind_i == KIND_FETCH && !pf_valid_o)
        |=> bus_start_o && !pf_hit_o)
        else $error("fetch after invalidation not issued");

endmodule

// ===== bus_target_model.sv
// Far-side model of the internal bus targets: memory controller and translation unit.
// Assumes the block's start pulse and a mode that the bench sets before each request.
`timescale 1ns/10ps
module bus_target_model
    import abort_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // Transfer start and bench control
    input  wire logic                  start_i,
    input  wire logic [2:0]            phases_i,
    input  wire logic [1:0]            mode_i,
    input  wire logic [2:0]            abort_at_i,
    input  wire logic [PHASE_BITS-1:0] base_i,
    // Completion events
    output logic                       valid_o,
    output logic [PHASE_BITS-1:0]      data_o,
    output logic                       last_o,
    output logic                       no_claim_o,
    output logic                       relay_o,
    output logic                       tabort_o,
    // Own error interrupt
    output logic                       irq_o
);
    // Mode 0 normal, 1 unclaimed, 2 relayed master-abort, 3 target-abort
    logic [2:0] n, idx;  // Phase count and position
    logic [1:0] m;       // Latched mode
    logic [2:0] ab;      // Aborted phase
    logic       act;     // Transfer running
    logic [3:0] logs;    // Error log entries in use
    // Level request, so many logged errors give one interrupt
    assign irq_o = (logs != 4'h0);
    logic [2:0] n_now, idx_now, ab_now;  // Values in force this cycle
    logic [1:0] m_now;
    logic       act_now;
    // A start takes effect in the cycle that sees it
    always_comb begin
        {n_now, idx_now, m_now, ab_now, act_now} = {n, idx, m, ab, act};
        if (start_i) begin
            n_now   = (phases_i == 3'h0) ? 3'h1 : phases_i;
            idx_now = 3'h0;
            {m_now, ab_now, act_now} = {mode_i, abort_at_i, 1'b1};
        end
    end
    // One phase a cycle; idle data inverts so stale data never looks valid
    always @(posedge clk_i) begin
        {valid_o, last_o, no_claim_o, relay_o, tabort_o} <= 5'h00;
        data_o <= ~data_o;
        {n, m, ab, idx, act} <= {n_now, m_now, ab_now, idx_now, act_now};
        if (!rst_n_i) begin
            act  <= 1'b0;
            logs <= 4'h0;
        end else if (act_now && m_now == 2'h1) begin
            no_claim_o <= 1'b1;
            act        <= 1'b0;
        end else if (act_now && m_now == 2'h2) begin
            relay_o <= 1'b1;  // Translation unit logs and interrupts itself
            logs    <= logs + 4'h1;
            act     <= 1'b0;
        end else if (act_now && m_now == 2'h3 && idx_now == ab_now) begin
            // Abort stands for a multi-bit error in checked memory
            tabort_o <= 1'b1;
            last_o   <= (idx_now == n_now - 3'h1);
            if (logs != 4'hF) logs <= logs + 4'h1;
            act      <= 1'b0;
        end else if (act_now) begin
            valid_o <= 1'b1;
            data_o  <= base_i + PHASE_BITS'(idx_now);
            last_o  <= (idx_now == n_now - 3'h1);
            act     <= (idx_now != n_now - 3'h1);
            idx     <= idx_now + 3'h1;
        end
    end
endmodule

// ===== core_bus_abort_handling_test.sv
// Self-checking bench of the abort handling block against the target model.
// Assumes one 50 MHz clock; inputs change and outputs are checked on the falling edge.
`timescale 1ns/10ps
module core_bus_abort_handling_test;
    import abort_pkg::*;
    logic                  clk_i, rst_n_i, req_valid_i, mem32_i, prefetch_en_i, mabort_clear_i;
    logic [1:0]            req_kind_i, mode;
    logic [2:0]            req_phases_i, abort_at, bus_phases_o;
    logic [31:0]           req_addr_i, bus_addr_o, pf_addr_o;
    logic [PHASE_BITS-1:0] bus_data_i, rd_data_o, base;
    logic                  bus_data_valid_i, bus_last_i, bus_no_claim_i, bus_relay_mabort_i;
    logic                  bus_target_abort_i, req_ready_o, bus_start_o, rd_valid_o, rd_last_o;
    logic                  wr_release_o, wr_discard_o, pf_valid_o, pf_hit_o, nmi_o, stat_exp;
    logic [7:0]            status_o;
    logic [64:0]           rdq[$];  // Expected {last, data} per read phase
    logic [34:0]           stq[$];  // Expected {address, phases} per bus start
    logic                  wrq[$];  // Expected discard per write release
    int                    seed = 12395;
    int                    errors, total_checks, cycles, hits, k;

    core_bus_abort_handling u_core_bus_abort_handling (
        .clk_i, .rst_n_i, .req_valid_i, .req_kind_i, .req_addr_i, .req_phases_i, .mem32_i,
        .prefetch_en_i, .bus_data_valid_i, .bus_data_i, .bus_last_i, .bus_no_claim_i,
        .bus_relay_mabort_i, .bus_target_abort_i, .mabort_clear_i, .req_ready_o, .bus_start_o,
        .bus_addr_o, .bus_phases_o, .rd_valid_o, .rd_data_o, .rd_last_o, .wr_release_o,
        .wr_discard_o, .pf_valid_o, .pf_addr_o, .pf_hit_o, .status_o, .nmi_o
    );
    bus_target_model u_bus_target_model (
        .clk_i, .rst_n_i, .start_i(bus_start_o), .phases_i(bus_phases_o), .mode_i(mode),
        .abort_at_i(abort_at), .base_i(base), .valid_o(bus_data_valid_i), .data_o(bus_data_i),
        .last_o(bus_last_i), .no_claim_o(bus_no_claim_i), .relay_o(bus_relay_mabort_i),
        .tabort_o(bus_target_abort_i), .irq_o()
    );

    // Clock generator
    initial begin
        clk_i = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end

    task automatic check_wide(input string name, input logic [64:0] exp, input logic [64:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_flag(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One transfer: notes expectations, requests, waits for idle; hit means no bus access
    task automatic xfer(input logic [1:0] kind, input logic [31:0] addr, input logic [2:0] ph,
                        input logic [1:0] md, input logic [2:0] at, input logic hit);
        logic [2:0] eff;
        int         i;
        eff = (kind == KIND_WRITE && ph > (mem32_i ? MAX_PHASES_32 : MAX_PHASES_64))
            ? (mem32_i ? MAX_PHASES_32 : MAX_PHASES_64) : ph;
        base = {$random(seed), $random(seed)};
        {mode, abort_at} = {md, at};
        if (!hit) stq.push_back({addr, eff});
        for (i = 0; i < eff && !hit && kind != KIND_WRITE; i++) begin
            if (md == 2'h1 || md == 2'h2 || (md == 2'h3 && i == at)) begin
                rdq.push_back({1'b1, {PHASE_BYTES{PAD_BYTE}}});  // Pad after last good phase
                break;
            end
            rdq.push_back({i == eff - 1, base + PHASE_BITS'(i)});
        end
        if (kind == KIND_WRITE) wrq.push_back(md == 2'h3 && at < eff - 1);
        if (md == 2'h1) stat_exp = 1'b1;
        for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) @(negedge clk_i);
        // Raised only while ready stands, so the next rising edge takes it
        {req_kind_i, req_addr_i, req_phases_i, req_valid_i} = {kind, addr, ph, 1'b1};
        @(negedge clk_i) req_valid_i = 1'b0;
        for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) @(negedge clk_i);
        @(negedge clk_i);
        check_flag("status", stat_exp, status_o[STAT_MABORT_BIT]);
        check_flag("nmi", stat_exp, nmi_o);
        check_flag("drained", 1'b1, rdq.size() + wrq.size() + stq.size() == 0);
    endtask

    // Watcher: each result takes the oldest note of its kind
    always @(negedge clk_i) begin
        if (rst_n_i && rd_valid_o === 1'b1)
            check_wide("read phase", (rdq.size() > 0) ? rdq.pop_front() : 'x,
                       {rd_last_o, rd_data_o});
        if (rst_n_i && bus_start_o === 1'b1)
            check_wide("bus start", (stq.size() > 0) ? 65'(stq.pop_front()) : '1,
                       65'({bus_addr_o, bus_phases_o}));
        if (rst_n_i && wr_release_o === 1'b1)
            check_flag("discard", (wrq.size() > 0) ? wrq.pop_front() : 1'bx, wr_discard_o);
        if (pf_hit_o === 1'b1) hits++;
    end

    // Hang guard well above the planned run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report;
        end
    end

    // Main sequence
    initial begin
        {rst_n_i, req_valid_i, req_kind_i, req_addr_i, req_phases_i, stat_exp} = '0;
        {mem32_i, prefetch_en_i, mabort_clear_i, mode, abort_at, base} = '0;
        repeat (4) @(negedge clk_i);
        rst_n_i = 1'b1;
        for (k = 0; k < 20 && req_ready_o !== 1'b1; k++) @(negedge clk_i);
        // Random plain reads
        repeat (4) xfer(KIND_READ, $random(seed), 3'h1 + 3'($random(seed) & 3), 2'h0, 3'h0, 1'b0);
        // Each abort kind on reads, target-aborts on fetches
        xfer(KIND_READ, 32'hA000_0000, 3'h2, 2'h2, 3'h0, 1'b0);
        xfer(KIND_FETCH, 32'hA000_0010, 3'h3, 2'h3, 3'h1, 1'b0);
        xfer(KIND_READ, 32'hA000_0020, 3'h4, 2'h3, 3'h3, 1'b0);
        xfer(KIND_READ, 32'hA000_0030, 3'h2, 2'h1, 3'h0, 1'b0);
        xfer(KIND_FETCH, 32'hA000_0040, 3'h1, 2'h3, 3'h0, 1'b0);
        // Flag holds until cleared
        mabort_clear_i = 1'b1;
        @(negedge clk_i) mabort_clear_i = 1'b0;
        stat_exp = 1'b0;
        @(negedge clk_i);
        check_flag("cleared", 1'b0, status_o[STAT_MABORT_BIT] | nmi_o);
        // Writes on both memory widths: clamp on 64-bit only, early abort, final-phase abort
        for (k = 0; k < 2; k++) begin
            mem32_i = k[0];
            xfer(KIND_WRITE, 32'hB000_0000, 3'h4, 2'h0, 3'h0, 1'b0);
            xfer(KIND_WRITE, 32'hB000_0040, 3'h4, 2'h3, 3'h0, 1'b0);
            xfer(KIND_WRITE, 32'hB000_0080, 3'h4, 2'h3, k[0] ? 3'h3 : 3'h1, 1'b0);
            xfer(KIND_WRITE, 32'hB000_00C0, 3'h2, k[0] ? 2'h2 : 2'h1, 3'h0, 1'b0);
        end
        // Prefetch load and hit, then aborted prefetch and refetch
        prefetch_en_i = 1'b1;
        xfer(KIND_PREFETCH, 32'hC000_0000, 3'h2, 2'h0, 3'h0, 1'b0);
        check_flag("pf loaded", 1'b1, pf_valid_o && pf_addr_o === 32'hC000_0000);
        xfer(KIND_FETCH, 32'hC000_0000, 3'h2, 2'h0, 3'h0, 1'b1);
        check_flag("pf hit", 1'b1, hits == 1);
        xfer(KIND_PREFETCH, 32'hC000_0040, 3'h2, 2'h3, 3'h1, 1'b0);
        check_flag("pf invalid", 1'b0, pf_valid_o);
        xfer(KIND_FETCH, 32'hC000_0040, 3'h2, 2'h0, 3'h0, 1'b0);
        final_report;
    end
endmodule
